/* logic/lcf_top.sv */
// lcf_top: config fabric register slave, fabric master and status outputs
// Functional notes
// R1: node id output mirrors base node register
// R2: unsupported packet, port disabled: drop, flag
// R3: master issues 24-bit address 32-bit data accesses
// R4: slave accepts register reads and writes
// R5: four byte strobes qualify write bytes
// R6: fabric answers 00 ok, 10 error
// R7: transfer only when valid and ready high
// R8: write response once address and data taken
module lcf_top
	import lcf_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        ARST_N,
	input  wire logic        S_AXI_CFGL_AWVALID,
	output      logic        S_AXI_CFGL_AWREADY,
	input  wire logic [23:0] S_AXI_CFGL_AWADDR,
	input  wire logic        S_AXI_CFGL_WVALID,
	output      logic        S_AXI_CFGL_WREADY,
	input  wire logic [31:0] S_AXI_CFGL_WDATA,
	input  wire logic [3:0]  S_AXI_CFGL_WSTRB,
	output      logic        S_AXI_CFGL_BVALID,
	input  wire logic        S_AXI_CFGL_BREADY,
	input  wire logic        S_AXI_CFGL_ARVALID,
	output      logic        S_AXI_CFGL_ARREADY,
	input  wire logic [23:0] S_AXI_CFGL_ARADDR,
	output      logic        S_AXI_CFGL_RVALID,
	input  wire logic        S_AXI_CFGL_RREADY,
	output      logic [31:0] S_AXI_CFGL_RDATA,
	output      logic        M_AXI_CFGR_AWVALID,
	input  wire logic        M_AXI_CFGR_AWREADY,
	output      logic [23:0] M_AXI_CFGR_AWADDR,
	output      logic [2:0]  M_AXI_CFGR_AWPROT,
	output      logic        M_AXI_CFGR_WVALID,
	input  wire logic        M_AXI_CFGR_WREADY,
	output      logic [31:0] M_AXI_CFGR_WDATA,
	output      logic [3:0]  M_AXI_CFGR_WSTRB,
	input  wire logic        M_AXI_CFGR_BVALID,
	output      logic        M_AXI_CFGR_BREADY,
	input  wire logic [1:0]  M_AXI_CFGR_BRESP,
	output      logic        M_AXI_CFGR_ARVALID,
	input  wire logic        M_AXI_CFGR_ARREADY,
	output      logic [23:0] M_AXI_CFGR_ARADDR,
	output      logic [2:0]  M_AXI_CFGR_ARPROT,
	input  wire logic        M_AXI_CFGR_RVALID,
	output      logic        M_AXI_CFGR_RREADY,
	input  wire logic [1:0]  M_AXI_CFGR_RRESP,
	input  wire logic [31:0] M_AXI_CFGR_RDATA,
	input  wire logic        CMD_VALID,
	output      logic        CMD_READY,
	input  wire lcf_cmd_t    CMD,
	output      logic        RSP_VALID,
	output      lcf_rsp_t    RSP,
	input  wire logic        UNSUP_RX,
	output      logic [15:0] NODE_ID,
	output      logic        UNSUP_DROP
);

	logic [31:0] base_node_ff;
	logic        udp_en_ff;
	logic        drop_ff;
	logic        aw_held_ff;
	logic        w_held_ff;
	logic [23:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0]  wstrb_ff;
	logic        bvalid_ff;
	logic        rvalid_ff;
	logic [31:0] rdata_ff;
	logic        aw_hs;
	logic        w_hs;
	logic        ar_hs;
	logic        wr_go;
	logic [23:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic        drop_ev;
	logic        drop_clr;
	logic [31:0] rd_mux;

	////////////////////////////////////////////////////////////////////////
	// write channel: address and data are taken independently and parked
	assign S_AXI_CFGL_AWREADY = !aw_held_ff && !bvalid_ff;
	assign S_AXI_CFGL_WREADY  = !w_held_ff && !bvalid_ff;
	assign aw_hs = S_AXI_CFGL_AWVALID && S_AXI_CFGL_AWREADY; // R7
	assign w_hs  = S_AXI_CFGL_WVALID && S_AXI_CFGL_WREADY; // R7
	assign wr_go = (aw_held_ff || aw_hs) && (w_held_ff || w_hs); // R8
	assign wr_addr = aw_held_ff ? awaddr_ff : S_AXI_CFGL_AWADDR;
	assign wr_data = w_held_ff ? wdata_ff : S_AXI_CFGL_WDATA;
	assign wr_strb = w_held_ff ? wstrb_ff : S_AXI_CFGL_WSTRB;
	assign S_AXI_CFGL_BVALID = bvalid_ff;

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			aw_held_ff <= 1'b0;
			awaddr_ff  <= '0;
		end else if (wr_go) begin
			aw_held_ff <= 1'b0;
		end else if (aw_hs) begin
			aw_held_ff <= 1'b1;
			awaddr_ff  <= S_AXI_CFGL_AWADDR;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			w_held_ff <= 1'b0;
			wdata_ff  <= '0;
			wstrb_ff  <= '0;
		end else if (wr_go) begin
			w_held_ff <= 1'b0;
		end else if (w_hs) begin
			w_held_ff <= 1'b1;
			wdata_ff  <= S_AXI_CFGL_WDATA;
			wstrb_ff  <= S_AXI_CFGL_WSTRB;
		end
	end

	// no response code on this port, so bvalid alone marks completion
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N)
			bvalid_ff <= 1'b0;
		else if (wr_go)
			bvalid_ff <= 1'b1; // R8
		else if (S_AXI_CFGL_BREADY)
			bvalid_ff <= 1'b0; // R7
	end

	////////////////////////////////////////////////////////////////////////
	// registers; writes to unmapped offsets are accepted and ignored
	for (genvar b = 0; b < STRB_W; b++) begin : g_lane
		always_ff @(posedge CLK or negedge ARST_N) begin
			if (!ARST_N)
				base_node_ff[8*b +: 8] <= RST_BASE_NODE[8*b +: 8];
			else if (wr_go && wr_addr[23:2] == OFF_BASE_NODE[23:2]
					&& wr_strb[b])
				base_node_ff[8*b +: 8] <= wr_data[8*b +: 8]; // R5
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N)
			udp_en_ff <= RST_UDP_EN;
		else if (wr_go && wr_addr[23:2] == OFF_CTRL[23:2] && wr_strb[0])
			udp_en_ff <= wr_data[CTRL_UDP_EN]; // R5
	end

	assign NODE_ID = base_node_ff[NODE_LSB +: NODE_W]; // R1

	// drop flag is sticky, write one to clear; a new drop beats the clear
	assign drop_ev  = UNSUP_RX && !udp_en_ff; // R2
	assign drop_clr = wr_go && wr_addr[23:2] == OFF_STATUS[23:2]
		&& wr_strb[0] && wr_data[STAT_DROP];

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N)
			drop_ff <= 1'b0;
		else if (drop_ev)
			drop_ff <= 1'b1; // R2
		else if (drop_clr)
			drop_ff <= 1'b0;
	end

	assign UNSUP_DROP = drop_ff;

	////////////////////////////////////////////////////////////////////////
	// read channel: one read in flight, unmapped offsets read zero
	assign S_AXI_CFGL_ARREADY = !rvalid_ff;
	assign ar_hs = S_AXI_CFGL_ARVALID && S_AXI_CFGL_ARREADY; // R7
	assign S_AXI_CFGL_RVALID = rvalid_ff;
	assign S_AXI_CFGL_RDATA  = rdata_ff;

	always_comb begin
		rd_mux = '0;
		case (S_AXI_CFGL_ARADDR[23:2])
			OFF_BASE_NODE[23:2]: rd_mux = base_node_ff;
			OFF_CTRL[23:2]:      rd_mux[CTRL_UDP_EN] = udp_en_ff;
			OFF_STATUS[23:2]:    rd_mux[STAT_DROP] = drop_ff;
			default:             rd_mux = '0;
		endcase
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= '0;
		end else if (ar_hs) begin
			rvalid_ff <= 1'b1; // R4
			rdata_ff  <= rd_mux;
		end else if (S_AXI_CFGL_RREADY) begin
			rvalid_ff <= 1'b0; // R7
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign M_AXI_CFGR_AWPROT = PROT_ZERO; // R3
	assign M_AXI_CFGR_ARPROT = PROT_ZERO; // R3

	lcf_master lcf_master_inst (
		.clk       (CLK),
		.arst_n    (ARST_N),
		.cmd_valid (CMD_VALID),
		.cmd_ready (CMD_READY),
		.cmd       (CMD),
		.rsp_valid (RSP_VALID),
		.rsp       (RSP),
		.awvalid   (M_AXI_CFGR_AWVALID),
		.awready   (M_AXI_CFGR_AWREADY),
		.awaddr    (M_AXI_CFGR_AWADDR),
		.wvalid    (M_AXI_CFGR_WVALID),
		.wready    (M_AXI_CFGR_WREADY),
		.wdata     (M_AXI_CFGR_WDATA),
		.wstrb     (M_AXI_CFGR_WSTRB),
		.bvalid    (M_AXI_CFGR_BVALID),
		.bready    (M_AXI_CFGR_BREADY),
		.bresp     (M_AXI_CFGR_BRESP),
		.arvalid   (M_AXI_CFGR_ARVALID),
		.arready   (M_AXI_CFGR_ARREADY),
		.araddr    (M_AXI_CFGR_ARADDR),
		.rvalid    (M_AXI_CFGR_RVALID),
		.rready    (M_AXI_CFGR_RREADY),
		.rresp     (M_AXI_CFGR_RRESP),
		.rdata     (M_AXI_CFGR_RDATA)
	);

	////////////////////////////////////////////////////////////////////////
	sequence s_full_node_wr;
		wr_go && wr_addr[23:2] == OFF_BASE_NODE[23:2] && wr_strb == 4'hf;
	endsequence
	property p_node_id;
		@(posedge CLK) disable iff (!ARST_N)
		s_full_node_wr |=> NODE_ID == $past(wr_data[15:0]);
	endproperty
	a_node_id: assert property (p_node_id) // R1
		else $error("node id does not follow base register write");

	property p_drop_set;
		@(posedge CLK) disable iff (!ARST_N)
		UNSUP_RX && !udp_en_ff |=> UNSUP_DROP;
	endproperty
	a_drop_set: assert property (p_drop_set) // R2
		else $error("unsupported drop not flagged");

	property p_drop_cause;
		@(posedge CLK) disable iff (!ARST_N)
		$rose(UNSUP_DROP) |-> $past(UNSUP_RX) && !$past(udp_en_ff);
	endproperty
	a_drop_cause: assert property (p_drop_cause) // R2
		else $error("drop flag set without a dropped packet");

	property p_strb_lane;
		@(posedge CLK) disable iff (!ARST_N)
		wr_go && wr_addr[23:2] == OFF_BASE_NODE[23:2] && !wr_strb[3]
			|=> base_node_ff[31:24] == $past(base_node_ff[31:24]);
	endproperty
	a_strb_lane: assert property (p_strb_lane) // R5
		else $error("unstrobed byte lane was written");

	sequence s_wr_taken;
		wr_go ##1 S_AXI_CFGL_BVALID;
	endsequence
	property p_bresp;
		@(posedge CLK) disable iff (!ARST_N)
		wr_go |-> s_wr_taken;
	endproperty
	a_bresp: assert property (p_bresp) // R8
		else $error("write completion not signalled");

	property p_b_hold;
		@(posedge CLK) disable iff (!ARST_N)
		S_AXI_CFGL_BVALID && !S_AXI_CFGL_BREADY |=> S_AXI_CFGL_BVALID;
	endproperty
	a_b_hold: assert property (p_b_hold) // R7
		else $error("write response withdrawn before ready");

	property p_r_hold;
		@(posedge CLK) disable iff (!ARST_N)
		S_AXI_CFGL_RVALID && !S_AXI_CFGL_RREADY
			|=> S_AXI_CFGL_RVALID && $stable(S_AXI_CFGL_RDATA);
	endproperty
	a_r_hold: assert property (p_r_hold) // R7
		else $error("read data changed before ready");

	property p_rd_answer;
		@(posedge CLK) disable iff (!ARST_N)
		ar_hs |=> S_AXI_CFGL_RVALID && S_AXI_CFGL_RDATA == $past(rd_mux);
	endproperty
	a_rd_answer: assert property (p_rd_answer) // R4
		else $error("read not answered next cycle");

	property p_prot;
		@(posedge CLK) disable iff (!ARST_N)
		M_AXI_CFGR_AWVALID || M_AXI_CFGR_ARVALID
			|-> M_AXI_CFGR_AWPROT == 3'h0 && M_AXI_CFGR_ARPROT == 3'h0;
	endproperty
	a_prot: assert property (p_prot) // R3
		else $error("protection outputs not zero");

endmodule : lcf_top

/* logic/lcf_pkg.sv */
// lcf_pkg: shared constants and carrier types for the config fabric block
package lcf_pkg;

	localparam int ADDR_W = 24;
	localparam int DATA_W = 32;
	localparam int STRB_W = 4;
	localparam int PROT_W = 3;
	localparam int RESP_W = 2;

	// register offsets on the register slave port
	localparam logic [23:0] OFF_BASE_NODE = 24'h000060;
	localparam logic [23:0] OFF_CTRL      = 24'h000064;
	localparam logic [23:0] OFF_STATUS    = 24'h000068;

	// field positions
	localparam int NODE_LSB     = 0;
	localparam int NODE_W       = 16;
	localparam int CTRL_UDP_EN  = 0;
	localparam int STAT_DROP    = 0;

	// values after reset, and the fixed protection code
	localparam logic [31:0] RST_BASE_NODE = 32'h0000_0000;
	localparam logic        RST_UDP_EN    = 1'b0;
	localparam logic [2:0]  PROT_ZERO     = 3'h0;

	// response codes from the fabric
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	localparam int         RESP_ERR_BIT = 1;

	typedef struct packed {
		logic        write;
		logic [23:0] addr;
		logic [31:0] data;
		logic [3:0]  strb;
	} lcf_cmd_t;

	typedef struct packed {
		logic [1:0]  resp;
		logic [31:0] data;
	} lcf_rsp_t;

	typedef enum logic [2:0] {
		MST_IDLE  = 3'b000,
		MST_WRITE = 3'b001,
		MST_WRESP = 3'b010,
		MST_READ  = 3'b011,
		MST_RRESP = 3'b100
	} lcf_mst_state_t;

endpackage : lcf_pkg

/* logic/lcf_master.sv */
// lcf_master: single-outstanding master engine into the config fabric
module lcf_master
	import lcf_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        cmd_valid,
	output      logic        cmd_ready,
	input  wire lcf_cmd_t    cmd,
	output      logic        rsp_valid,
	output      lcf_rsp_t    rsp,
	output      logic        awvalid,
	input  wire logic        awready,
	output      logic [23:0] awaddr,
	output      logic        wvalid,
	input  wire logic        wready,
	output      logic [31:0] wdata,
	output      logic [3:0]  wstrb,
	input  wire logic        bvalid,
	output      logic        bready,
	input  wire logic [1:0]  bresp,
	output      logic        arvalid,
	input  wire logic        arready,
	output      logic [23:0] araddr,
	input  wire logic        rvalid,
	output      logic        rready,
	input  wire logic [1:0]  rresp,
	input  wire logic [31:0] rdata
);

	lcf_mst_state_t state_ff;
	lcf_mst_state_t nxt_state;
	lcf_cmd_t       cmd_ff;
	logic           aw_done_ff;
	logic           w_done_ff;
	logic           rsp_valid_ff;
	lcf_rsp_t       rsp_ff;
	logic           aw_hs;
	logic           w_hs;

	assign cmd_ready = (state_ff == MST_IDLE);
	assign awvalid   = (state_ff == MST_WRITE) && !aw_done_ff; // R3
	assign wvalid    = (state_ff == MST_WRITE) && !w_done_ff;
	assign bready    = (state_ff == MST_WRESP);
	assign arvalid   = (state_ff == MST_READ);
	assign rready    = (state_ff == MST_RRESP);
	assign awaddr    = cmd_ff.addr;
	assign araddr    = cmd_ff.addr;
	assign wdata     = cmd_ff.data;
	assign wstrb     = cmd_ff.strb; // R5
	assign aw_hs     = awvalid && awready; // R7
	assign w_hs      = wvalid && wready; // R7
	assign rsp_valid = rsp_valid_ff;
	assign rsp       = rsp_ff;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			MST_IDLE: begin
				if (cmd_valid)
					nxt_state = cmd.write ? MST_WRITE : MST_READ;
			end
			MST_WRITE: begin
				// address and data may be taken in either order
				if ((aw_done_ff || aw_hs) && (w_done_ff || w_hs))
					nxt_state = MST_WRESP;
			end
			MST_WRESP: begin
				if (bvalid)
					nxt_state = MST_IDLE;
			end
			MST_READ: begin
				if (arready)
					nxt_state = MST_RRESP;
			end
			MST_RRESP: begin
				if (rvalid)
					nxt_state = MST_IDLE;
			end
			default: nxt_state = MST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			state_ff <= MST_IDLE;
		else
			state_ff <= nxt_state;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			cmd_ff <= '0;
		else if (cmd_valid && cmd_ready)
			cmd_ff <= cmd;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_done_ff <= 1'b0;
			w_done_ff  <= 1'b0;
		end else if (state_ff != MST_WRITE) begin
			aw_done_ff <= 1'b0;
			w_done_ff  <= 1'b0;
		end else begin
			aw_done_ff <= aw_done_ff || aw_hs; // R7
			w_done_ff  <= w_done_ff || w_hs;
		end
	end

	// reserved codes pass through unchanged; the user sees the raw code
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rsp_valid_ff <= 1'b0;
			rsp_ff       <= '0;
		end else if (bready && bvalid) begin
			rsp_valid_ff <= 1'b1;
			rsp_ff       <= '{resp: bresp, data: '0}; // R6
		end else if (rready && rvalid) begin
			rsp_valid_ff <= 1'b1;
			rsp_ff       <= '{resp: rresp, data: rdata}; // R6
		end else begin
			rsp_valid_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	property p_aw_hold;
		@(posedge clk) disable iff (!arst_n)
		awvalid && !awready |=> awvalid && $stable(awaddr);
	endproperty
	a_aw_hold: assert property (p_aw_hold) // R7
		else $error("write address dropped before ready");

	property p_ar_hold;
		@(posedge clk) disable iff (!arst_n)
		arvalid && !arready |=> arvalid && $stable(araddr);
	endproperty
	a_ar_hold: assert property (p_ar_hold) // R7
		else $error("read address dropped before ready");

	sequence s_rd_done;
		rready && rvalid;
	endsequence
	property p_rd_rsp;
		@(posedge clk) disable iff (!arst_n)
		s_rd_done |=> rsp_valid && rsp.data == $past(rdata)
			&& rsp.resp == $past(rresp);
	endproperty
	a_rd_rsp: assert property (p_rd_rsp) // R3
		else $error("read response not returned to user");

endmodule : lcf_master

/* verification/lcf_fabric_model.sv */
// lcf_fabric_model: behavioural config fabric behind the master port
module lcf_fabric_model
	import lcf_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        M_AXI_CFGR_AWVALID,
	output      logic        M_AXI_CFGR_AWREADY,
	input  wire logic [23:0] M_AXI_CFGR_AWADDR,
	input  wire logic        M_AXI_CFGR_WVALID,
	output      logic        M_AXI_CFGR_WREADY,
	input  wire logic [31:0] M_AXI_CFGR_WDATA,
	input  wire logic [3:0]  M_AXI_CFGR_WSTRB,
	output      logic        M_AXI_CFGR_BVALID,
	input  wire logic        M_AXI_CFGR_BREADY,
	output      logic [1:0]  M_AXI_CFGR_BRESP,
	input  wire logic        M_AXI_CFGR_ARVALID,
	output      logic        M_AXI_CFGR_ARREADY,
	input  wire logic [23:0] M_AXI_CFGR_ARADDR,
	output      logic        M_AXI_CFGR_RVALID,
	input  wire logic        M_AXI_CFGR_RREADY,
	output      logic [1:0]  M_AXI_CFGR_RRESP,
	output      logic [31:0] M_AXI_CFGR_RDATA,
	input  wire logic [1:0]  dly,
	input  wire logic [1:0]  code,
	input  wire logic [31:0] rd_word,
	output      lcf_cmd_t    seen
);
	timeunit 1ns;
	timeprecision 1ns;
	int n;
	initial begin
		{M_AXI_CFGR_AWREADY, M_AXI_CFGR_WREADY, M_AXI_CFGR_ARREADY} = 3'h0;
		{M_AXI_CFGR_BVALID, M_AXI_CFGR_RVALID} = 2'h0;
		{M_AXI_CFGR_BRESP, M_AXI_CFGR_RRESP} = 4'h5;
		M_AXI_CFGR_RDATA = 32'h5a5a_a5a5;
		seen = '0;
	end
	task automatic tick;
		@(posedge CLK);
		#10;
	endtask : tick
	// readies raised only after a set stall; valids must hold meanwhile
	always begin
		tick();
		if (M_AXI_CFGR_AWVALID === 1'b1) begin
			repeat (dly) tick();
			seen = {1'b1, M_AXI_CFGR_AWADDR, M_AXI_CFGR_WDATA, M_AXI_CFGR_WSTRB};
			M_AXI_CFGR_AWREADY = 1'b1;
			M_AXI_CFGR_WREADY = 1'b1;
			tick();
			M_AXI_CFGR_AWREADY = 1'b0;
			M_AXI_CFGR_WREADY = 1'b0;
			M_AXI_CFGR_BVALID = 1'b1;
			M_AXI_CFGR_BRESP = code;
			for (n = 0; M_AXI_CFGR_BREADY !== 1'b1 && n < 64; n++) tick();
			tick();
			M_AXI_CFGR_BVALID = 1'b0;
			// released: show the inverse, never the stale code
			M_AXI_CFGR_BRESP = ~code;
		end else if (M_AXI_CFGR_ARVALID === 1'b1) begin
			repeat (dly) tick();
			seen = {1'b0, M_AXI_CFGR_ARADDR, 32'h0, 4'h0};
			M_AXI_CFGR_ARREADY = 1'b1;
			tick();
			M_AXI_CFGR_ARREADY = 1'b0;
			M_AXI_CFGR_RVALID = 1'b1;
			M_AXI_CFGR_RRESP = code;
			M_AXI_CFGR_RDATA = rd_word;
			for (n = 0; M_AXI_CFGR_RREADY !== 1'b1 && n < 64; n++) tick();
			tick();
			M_AXI_CFGR_RVALID = 1'b0;
			M_AXI_CFGR_RRESP = ~code;
			M_AXI_CFGR_RDATA = ~rd_word;
		end
	end
endmodule : lcf_fabric_model

/* verification/tb_lcf_top.sv */
// tb_lcf_top: random and corner tests of the config fabric block
module tb_lcf_top import lcf_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        CLK, ARST_N, UNSUP_RX, UNSUP_DROP, CMD_VALID, CMD_READY;
	logic        RSP_VALID;
	logic        S_AXI_CFGL_AWVALID, S_AXI_CFGL_AWREADY, S_AXI_CFGL_WVALID;
	logic        S_AXI_CFGL_WREADY, S_AXI_CFGL_BVALID, S_AXI_CFGL_BREADY;
	logic        S_AXI_CFGL_ARVALID, S_AXI_CFGL_ARREADY, S_AXI_CFGL_RVALID;
	logic        S_AXI_CFGL_RREADY;
	logic [23:0] S_AXI_CFGL_AWADDR, S_AXI_CFGL_ARADDR;
	logic [31:0] S_AXI_CFGL_WDATA, S_AXI_CFGL_RDATA;
	logic [3:0]  S_AXI_CFGL_WSTRB;
	logic        M_AXI_CFGR_AWVALID, M_AXI_CFGR_AWREADY, M_AXI_CFGR_WVALID;
	logic        M_AXI_CFGR_WREADY, M_AXI_CFGR_BVALID, M_AXI_CFGR_BREADY;
	logic        M_AXI_CFGR_ARVALID, M_AXI_CFGR_ARREADY, M_AXI_CFGR_RVALID;
	logic        M_AXI_CFGR_RREADY;
	logic [23:0] M_AXI_CFGR_AWADDR, M_AXI_CFGR_ARADDR;
	logic [2:0]  M_AXI_CFGR_AWPROT, M_AXI_CFGR_ARPROT;
	logic [31:0] M_AXI_CFGR_WDATA, M_AXI_CFGR_RDATA;
	logic [3:0]  M_AXI_CFGR_WSTRB, strb;
	logic [1:0]  M_AXI_CFGR_BRESP, M_AXI_CFGR_RRESP, dly, code;
	logic [15:0] NODE_ID;
	logic [31:0] seed, shadow, got, rd_word;
	lcf_cmd_t    CMD, seen;
	lcf_rsp_t    RSP;
	int          failures, tests_run, cycles;

	lcf_top lcf_top_inst (.CLK, .ARST_N, .S_AXI_CFGL_AWVALID, .S_AXI_CFGL_AWREADY,
		.S_AXI_CFGL_AWADDR, .S_AXI_CFGL_WVALID, .S_AXI_CFGL_WREADY,
		.S_AXI_CFGL_WDATA, .S_AXI_CFGL_WSTRB, .S_AXI_CFGL_BVALID,
		.S_AXI_CFGL_BREADY, .S_AXI_CFGL_ARVALID, .S_AXI_CFGL_ARREADY,
		.S_AXI_CFGL_ARADDR, .S_AXI_CFGL_RVALID, .S_AXI_CFGL_RREADY,
		.S_AXI_CFGL_RDATA, .M_AXI_CFGR_AWVALID, .M_AXI_CFGR_AWREADY,
		.M_AXI_CFGR_AWADDR, .M_AXI_CFGR_AWPROT, .M_AXI_CFGR_WVALID,
		.M_AXI_CFGR_WREADY, .M_AXI_CFGR_WDATA, .M_AXI_CFGR_WSTRB,
		.M_AXI_CFGR_BVALID, .M_AXI_CFGR_BREADY, .M_AXI_CFGR_BRESP,
		.M_AXI_CFGR_ARVALID, .M_AXI_CFGR_ARREADY, .M_AXI_CFGR_ARADDR,
		.M_AXI_CFGR_ARPROT, .M_AXI_CFGR_RVALID, .M_AXI_CFGR_RREADY,
		.M_AXI_CFGR_RRESP, .M_AXI_CFGR_RDATA, .CMD_VALID, .CMD_READY, .CMD,
		.RSP_VALID, .RSP, .UNSUP_RX, .NODE_ID, .UNSUP_DROP);

	lcf_fabric_model lcf_fabric_model_inst (.CLK, .M_AXI_CFGR_AWVALID,
		.M_AXI_CFGR_AWREADY, .M_AXI_CFGR_AWADDR, .M_AXI_CFGR_WVALID,
		.M_AXI_CFGR_WREADY, .M_AXI_CFGR_WDATA, .M_AXI_CFGR_WSTRB,
		.M_AXI_CFGR_BVALID, .M_AXI_CFGR_BREADY, .M_AXI_CFGR_BRESP,
		.M_AXI_CFGR_ARVALID, .M_AXI_CFGR_ARREADY, .M_AXI_CFGR_ARADDR,
		.M_AXI_CFGR_RVALID, .M_AXI_CFGR_RREADY, .M_AXI_CFGR_RRESP,
		.M_AXI_CFGR_RDATA, .dly, .code, .rd_word, .seen);

	initial begin
		CLK = 1'b0;
		forever #50 CLK = ~CLK;
	end
	// the whole run needs well under 2000 cycles
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			finish_test();
		end
	end
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	function automatic logic [31:0] merge(input logic [31:0] o, n,
		input logic [3:0] s);
		for (int i = 0; i < 4; i++) if (s[i]) o[8*i +: 8] = n[8*i +: 8];
		return o;
	endfunction : merge
	task automatic tick;
		@(posedge CLK);
		#10;
	endtask : tick
	task automatic chk(input logic [31:0] g, e);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic finish_test;
		$display("counts: %0d compares, %0d mismatches", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : finish_test
	task automatic wr(input logic [23:0] a, input logic [31:0] d,
		input logic [3:0] s);
		S_AXI_CFGL_AWADDR = a;
		S_AXI_CFGL_WDATA = d;
		S_AXI_CFGL_WSTRB = s;
		{S_AXI_CFGL_AWVALID, S_AXI_CFGL_WVALID} = 2'h3;
		for (int n = 0; n < 20 && !(S_AXI_CFGL_AWREADY === 1'b1 &&
			S_AXI_CFGL_WREADY === 1'b1); n++) tick();
		tick();
		{S_AXI_CFGL_AWVALID, S_AXI_CFGL_WVALID} = 2'h0;
		S_AXI_CFGL_BREADY = 1'b1;
		chk(S_AXI_CFGL_BVALID, 32'h1);
		chk(S_AXI_CFGL_AWREADY, 32'h0);
		tick();
		S_AXI_CFGL_BREADY = 1'b0;
	endtask : wr
	task automatic rd(input logic [23:0] a, output logic [31:0] d);
		S_AXI_CFGL_ARADDR = a;
		S_AXI_CFGL_ARVALID = 1'b1;
		for (int n = 0; n < 20 && S_AXI_CFGL_ARREADY !== 1'b1; n++) tick();
		tick();
		S_AXI_CFGL_ARVALID = 1'b0;
		S_AXI_CFGL_RREADY = 1'b1;
		chk(S_AXI_CFGL_RVALID, 32'h1);
		chk(S_AXI_CFGL_ARREADY, 32'h0);
		d = S_AXI_CFGL_RDATA;
		tick();
		S_AXI_CFGL_RREADY = 1'b0;
	endtask : rd
	// one master command against a fabric that stalls 0..3 cycles
	task automatic mc(input logic w, input logic [1:0] c);
		seed = xs(seed);
		CMD = {w, seed[23:0], xs(seed), seed[31:28]};
		dly = seed[25:24];
		code = c;
		rd_word = ~seed;
		CMD_VALID = 1'b1;
		for (int n = 0; n < 20 && CMD_READY !== 1'b1; n++) tick();
		tick();
		CMD_VALID = 1'b0;
		chk(CMD_READY, 32'h0);
		for (int n = 0; n < 40 && RSP_VALID !== 1'b1; n++) tick();
		chk(RSP_VALID, 32'h1);
		chk(CMD_READY, 32'h1);
		chk(RSP.resp, c);
		chk(RSP.data, w ? 32'h0 : rd_word);
		chk(seen.write, w);
		chk(seen.addr, CMD.addr);
		chk(seen.data, w ? CMD.data : 32'h0);
		chk(seen.strb, w ? CMD.strb : 4'h0);
		tick();
	endtask : mc
	////////////////////////////////////////////////////////////////////////
	initial begin
		{S_AXI_CFGL_AWVALID, S_AXI_CFGL_WVALID, S_AXI_CFGL_BREADY} = 3'h0;
		{S_AXI_CFGL_ARVALID, S_AXI_CFGL_RREADY, CMD_VALID, UNSUP_RX} = 4'h0;
		{S_AXI_CFGL_AWADDR, S_AXI_CFGL_ARADDR, S_AXI_CFGL_WDATA} = '0;
		{S_AXI_CFGL_WSTRB, CMD, dly, code, rd_word} = '0;
		ARST_N = 1'b0;
		seed = 32'h0000_0026;
		repeat (16) @(posedge CLK);
		#10;
		ARST_N = 1'b1;
		chk(NODE_ID, 32'h0);
		chk(UNSUP_DROP, 32'h0);
		rd(OFF_BASE_NODE, got);
		chk(got, RST_BASE_NODE);
		$display("test reset values done");
		shadow = RST_BASE_NODE;
		for (int i = 0; i < 10; i++) begin
			seed = xs(seed);
			strb = (i == 0) ? 4'hf : (i == 1) ? 4'h0 : seed[3:0];
			shadow = merge(shadow, seed, strb);
			wr(OFF_BASE_NODE, seed, strb);
			chk(NODE_ID, shadow[15:0]);
			rd(OFF_BASE_NODE, got);
			chk(got, shadow);
		end
		wr(24'h000100, 32'hffff_ffff, 4'hf);
		rd(24'h000100, got);
		chk(got, 32'h0);
		rd(OFF_BASE_NODE, got);
		chk(got, shadow);
		$display("test node register done");
		UNSUP_RX = 1'b1;
		tick();
		UNSUP_RX = 1'b0;
		chk(UNSUP_DROP, 32'h1);
		rd(OFF_STATUS, got);
		chk(got[STAT_DROP], 32'h1);
		wr(OFF_STATUS, 32'h1, 4'hf);
		chk(UNSUP_DROP, 32'h0);
		// drop only on the edge that takes the clear: the drop must win
		UNSUP_RX = 1'b1;
		fork
			wr(OFF_STATUS, 32'h1, 4'h1);
			begin
				tick();
				UNSUP_RX = 1'b0;
			end
		join
		chk(UNSUP_DROP, 32'h1);
		wr(OFF_STATUS, 32'h1, 4'h1);
		chk(UNSUP_DROP, 32'h0);
		wr(OFF_CTRL, 32'h1, 4'h1);
		rd(OFF_CTRL, got);
		chk(got, 32'h1);
		UNSUP_RX = 1'b1;
		tick();
		UNSUP_RX = 1'b0;
		tick();
		chk(UNSUP_DROP, 32'h0);
		$display("test drop flag done");
		// every response code, reserved ones too, on writes and reads
		for (int i = 0; i < 8; i++) mc(i[0], i[2:1]);
		for (int i = 0; i < 10; i++) mc(seed[7], {seed[9], 1'b0});
		chk({M_AXI_CFGR_AWPROT, M_AXI_CFGR_ARPROT}, 32'h0);
		$display("test master port done");
		finish_test();
	end
endmodule : tb_lcf_top
